// file: core/omp_cfg.svh
`ifndef OMP_CFG_SVH
`define OMP_CFG_SVH

// ====================================================================
// Two-wire link constants
// ====================================================================
// Seven-bit bus address of the management memory.
`define OMP_DEV_ADDR 7'h50
// Highest write-protected byte; bytes above it are user memory.
`define OMP_WP_TOP 8'h7f
// Number of user memory bytes.
`define OMP_RAM_WORDS 128
// Bit counter value of the eighth bit of a byte.
`define OMP_LAST_BIT 3'h7
// Number of bytes in the monitor snapshot window.
`define OMP_SNAP_BYTES 16

// ====================================================================
// Memory map of the snapshot window
// ====================================================================
// First byte of the five monitor words, high byte first.
`define OMP_A_MON 4'h0
// Three bytes of alarm and warning flags, low byte first.
`define OMP_A_FLAG 4'ha
// Live status byte.
`define OMP_A_STAT 4'hd

// ====================================================================
// Timing
// ====================================================================
// System clock rate in MHz.
`define OMP_CLK_MHZ 20
// Least time that the link is held in reset after power-down falls, ns.
`define OMP_RST_NS 1000
// Same time in system clock cycles, rounded up.
`define OMP_RST_CYC 5'((`OMP_RST_NS * `OMP_CLK_MHZ + 999) / 1000)

// ====================================================================
// Factory thresholds: high alarm, low alarm, high warning, low warning
// ====================================================================
`define OMP_THR_TEMP {16'hc000, 16'h1000, 16'hb000, 16'h2000}
`define OMP_THR_BIAS {16'hc000, 16'h1000, 16'hb000, 16'h2000}
`define OMP_THR_TXP {16'hc000, 16'h1000, 16'hb000, 16'h2000}
`define OMP_THR_RXP {16'hc000, 16'h1000, 16'hb000, 16'h2000}
`define OMP_THR_VCC {16'hc000, 16'h1000, 16'hb000, 16'h2000}

`endif

// file: core/omp_pkg.sv
package omp_pkg;

    // ================================================================
    // Link state machine, Gray coded along the usual path
    // ================================================================
    typedef enum logic [3:0] {
        OMP_IDLE = 4'h0,
        OMP_ADDR = 4'h1,
        OMP_ADDR_ACK = 4'h3,
        OMP_PTR = 4'h2,
        OMP_PTR_ACK = 4'h6,
        OMP_WDATA = 4'h7,
        OMP_WDATA_ACK = 4'h5,
        OMP_RDATA = 4'h4,
        OMP_RDATA_ACK = 4'hc
    } omp_link_state_t;

    // State of the link side, clocked by the falling serial clock.
    typedef struct packed {
        omp_link_state_t st;
        logic [2:0] bits;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic sda_oe;
        logic desel_s1;
        logic desel_s2;
        logic st_seen;
        logic sp_seen;
    } omp_link_t;

    // One set of factory thresholds.
    typedef struct packed {
        logic [15:0] hi_alarm;
        logic [15:0] lo_alarm;
        logic [15:0] hi_warn;
        logic [15:0] lo_warn;
    } omp_thr_t;

    // Alarm and warning flags of one monitored value.
    typedef struct packed {
        logic hi_alarm;
        logic lo_alarm;
        logic hi_warn;
        logic lo_warn;
    } omp_flag_t;

    // State of the system side.
    typedef struct packed {
        logic [2:0] pd_sy;
        logic [1:0] off_sy;
        logic [1:0] los_sy;
        logic [1:0] tlol_sy;
        logic [1:0] rlol_sy;
        logic [2:0] stt_sy;
        logic [4:0] rst_cnt;
        logic link_clear;
        logic [15:0][7:0] snap;
        omp_flag_t [4:0] flags;
        logic int_oe;
        logic nr_oe;
        logic los_oe;
        logic laser_en;
        logic standby;
    } omp_sys_t;

endpackage

// file: core/omp_twi_link.sv
`include "omp_cfg.svh"

module omp_twi_link
    import omp_pkg::*;
(
    // Serial pins.
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // Control from the system side.
    input wire logic i_link_clear,
    input wire logic i_deselect,
    input wire logic [15:0][7:0] i_snap,
    // Start event toggle towards the system side.
    output logic o_start_tog
);

    // ================================================================
    // Edge samplers
    // ================================================================
    logic sda_rise;
    logic start_tog;
    logic stop_tog;
    logic start_ev;
    logic stop_ev;
    logic quiet;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [7:0] ram [`OMP_RAM_WORDS];
    omp_link_t r;
    omp_link_t next_r;

    // Data is taken on the rising edge of the host's clock. [RQ10] [RQ9]
    always_ff @(posedge i_scl or posedge i_link_clear) begin
        if (i_link_clear) begin
            sda_rise <= 1'b1;
        end else begin
            sda_rise <= i_sda;
        end
    end

    // Data falling while the clock is high marks a start. [RQ13] [RQ18]
    always_ff @(negedge i_sda or posedge i_link_clear) begin
        if (i_link_clear) begin
            start_tog <= 1'b0;
        end else if (i_scl) begin
            start_tog <= ~start_tog;
        end
    end

    // Data rising while the clock is high marks a stop. [RQ13] [RQ18]
    always_ff @(posedge i_sda or posedge i_link_clear) begin
        if (i_link_clear) begin
            stop_tog <= 1'b0;
        end else if (i_scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    assign start_ev = start_tog != r.st_seen;
    assign stop_ev = stop_tog != r.sp_seen;
    assign quiet = !r.desel_s2 && !start_ev && !stop_ev;
    assign wr_byte = {r.shreg[6:0], sda_rise};
    assign o_start_tog = start_tog;
    // Open-drain data: driven only low, released while the host drives. [RQ12]
    assign o_sda_oe = r.sda_oe;

    // ================================================================
    // Byte memory: snapshot, protected zeros, then user bytes
    // ================================================================
    // Addresses run upward from zero to the top of memory. [RQ14]
    always_comb begin
        if (r.ptr < 8'(`OMP_SNAP_BYTES)) begin
            rd_byte = i_snap[r.ptr[3:0]];
        end else if (r.ptr > `OMP_WP_TOP) begin
            rd_byte = ram[r.ptr[6:0]];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ================================================================
    // Protocol state machine
    // ================================================================
    always_comb begin
        next_r = r;
        wr_en = 1'b0;
        next_r.desel_s1 = i_deselect;
        next_r.desel_s2 = r.desel_s1;
        next_r.st_seen = start_tog;
        next_r.sp_seen = stop_tog;
        if (r.desel_s2) begin
            // Traffic is ignored while the module is deselected. [RQ1]
            next_r.st = OMP_IDLE;
            next_r.sda_oe = 1'b0;
        end else if (start_ev) begin
            next_r.st = OMP_ADDR;
            next_r.bits = 3'h0;
            next_r.sda_oe = 1'b0;
        end else if (stop_ev) begin
            next_r.st = OMP_IDLE;
            next_r.sda_oe = 1'b0;
        end else begin
            case (r.st)
                OMP_ADDR, OMP_PTR, OMP_WDATA: begin
                    next_r.shreg = wr_byte;
                    next_r.bits = r.bits + 3'h1;
                    if (r.bits == `OMP_LAST_BIT) begin
                        // Acknowledge by pulling data low. [RQ18]
                        next_r.sda_oe = 1'b1;
                        if (r.st == OMP_ADDR) begin
                            next_r.rw = wr_byte[0];
                            next_r.st = OMP_ADDR_ACK;
                            if (wr_byte[7:1] != `OMP_DEV_ADDR) begin
                                next_r.st = OMP_IDLE;
                                next_r.sda_oe = 1'b0;
                            end
                        end else if (r.st == OMP_PTR) begin
                            next_r.ptr = wr_byte;
                            next_r.st = OMP_PTR_ACK;
                        end else begin
                            // Only unprotected bytes take data. [RQ10]
                            wr_en = r.ptr > `OMP_WP_TOP;
                            next_r.ptr = r.ptr + 8'h01;
                            next_r.st = OMP_WDATA_ACK;
                        end
                    end
                end
                OMP_ADDR_ACK, OMP_RDATA_ACK: begin
                    next_r.sda_oe = 1'b0;
                    next_r.bits = 3'h0;
                    if (r.st == OMP_ADDR_ACK && !r.rw) begin
                        next_r.st = OMP_PTR;
                    end else if (r.st == OMP_RDATA_ACK && sda_rise) begin
                        next_r.st = OMP_IDLE;
                    end else begin
                        // Read data changes on the falling edge. [RQ11] [RQ14]
                        next_r.shreg = rd_byte;
                        next_r.sda_oe = ~rd_byte[7];
                        next_r.ptr = r.ptr + 8'h01;
                        next_r.st = OMP_RDATA;
                    end
                end
                OMP_PTR_ACK, OMP_WDATA_ACK: begin
                    next_r.sda_oe = 1'b0;
                    next_r.bits = 3'h0;
                    next_r.st = OMP_WDATA;
                end
                OMP_RDATA: begin
                    next_r.bits = r.bits + 3'h1;
                    if (r.bits == `OMP_LAST_BIT) begin
                        next_r.sda_oe = 1'b0;
                        next_r.st = OMP_RDATA_ACK;
                    end else begin
                        // Next bit goes out on this falling edge. [RQ11]
                        next_r.shreg = {r.shreg[6:0], 1'b0};
                        next_r.sda_oe = ~r.shreg[6];
                    end
                end
                default: begin
                    next_r.st = OMP_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // The link clock may stop, so the system side clears this logic directly.
    always_ff @(negedge i_scl or posedge i_link_clear) begin
        if (i_link_clear) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // User memory write port.
    always_ff @(negedge i_scl) begin
        if (wr_en) begin
            ram[r.ptr[6:0]] <= wr_byte;
        end
    end

    // ================================================================
    // Checks
    // ================================================================
    desel_release_a: assert property ( // [RQ1]
        @(negedge i_scl) disable iff (i_link_clear)
        r.desel_s2 |=> (!o_sda_oe && r.st == OMP_IDLE))
        else $error("Data line driven while deselected.");

    addr_ack_a: assert property ( // [RQ18]
        @(negedge i_scl) disable iff (i_link_clear)
        (quiet && r.st == OMP_ADDR && r.bits == `OMP_LAST_BIT
            && wr_byte[7:1] == `OMP_DEV_ADDR) |=> (o_sda_oe && r.st == OMP_ADDR_ACK))
        else $error("Own address not acknowledged.");

    write_protect_a: assert property ( // [RQ10]
        @(negedge i_scl) disable iff (i_link_clear)
        (quiet && r.st == OMP_WDATA && r.bits == `OMP_LAST_BIT) |-> (wr_en == (r.ptr > `OMP_WP_TOP)))
        else $error("Write protection not honoured.");

    read_msb_a: assert property ( // [RQ11]
        @(negedge i_scl) disable iff (i_link_clear)
        (quiet && r.st == OMP_ADDR_ACK && r.rw) |=> (o_sda_oe == !$past(rd_byte[7])))
        else $error("First read bit not driven on the falling edge.");

endmodule

// file: core/omp_mgmt_port.sv
// Overview of operation
// RQ1: With deselect high the serial link ignores all bus traffic.
// RQ2: Interrupt pin pulls low on any alarm or not-ready; both readable serially.
// RQ3: Laser off while the transmitter-disable request is high.
// RQ4: Presence pin is always pulled to ground.
// RQ5: Not-ready is the OR of signal loss and both lock losses.
// RQ6: Power-down high keeps the module in low-power stand-by.
// RQ7: Power-down falling edge resets everything, the serial link included; the code leaves user memory bytes unreset.
// RQ8: Reference clock inputs have no effect.
// RQ9: The host makes the serial clock; the module never drives it.
// RQ10: Write data taken on clock rise, stored only to unprotected bytes.
// RQ11: Read data changes on the falling clock edge.
// RQ12: Data line is open drain, each side releasing while the other drives.
// RQ13: The host marks transaction start and end using data against clock.
// RQ14: Memory is bytes, random or sequential, addresses rising from zero.
// RQ15: Temperature, bias, transmit and receive power, supply readable live.
// RQ16: Alarm and warning flags set when a value leaves its factory range.
// RQ17: Signal-loss pin low in normal reception, high when no signal.
// RQ18: Start, stop, acknowledge and address phase follow usual two-wire rules.
`include "omp_cfg.svh"

module omp_mgmt_port
    import omp_pkg::*;
(
    // Clock, reset and enable.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Host control pins.
    input wire logic i_deselect,
    input wire logic i_laser_off_req,
    input wire logic i_power_down,
    input wire logic i_ref_clock_in_p,
    input wire logic i_ref_clock_in_n,
    // Two-wire link.
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // Monitor values from on-chip converters.
    input wire logic [15:0] i_temp,
    input wire logic [15:0] i_bias,
    input wire logic [15:0] i_tx_pwr,
    input wire logic [15:0] i_rx_pwr,
    input wire logic [15:0] i_vcc,
    // Optical status from the data path.
    input wire logic i_rx_signal_lost,
    input wire logic i_tx_lol,
    input wire logic i_rx_lol,
    // Open-collector status pins, high enable pulls the pin low.
    output logic o_interrupt_oe,
    output logic o_absent_oe,
    output logic o_not_ready_flag_oe,
    output logic o_rx_signal_lost_oe,
    // Laser and power control.
    output logic o_laser_en,
    output logic o_standby
);

    // ================================================================
    // Declarations
    // ================================================================
    localparam omp_thr_t [4:0] THR = {`OMP_THR_VCC, `OMP_THR_RXP, `OMP_THR_TXP,
        `OMP_THR_BIAS, `OMP_THR_TEMP};

    omp_sys_t r;
    omp_sys_t next_r;
    logic [4:0][15:0] mon;
    logic start_tog;
    logic pd_fall;
    logic start_ev;
    logic not_ready;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset || !i_clk_en);

    // Monitor words, temperature first.
    assign mon = {i_vcc, i_rx_pwr, i_tx_pwr, i_bias, i_temp};

    // ================================================================
    // Serial link, clocked by the host's serial clock
    // ================================================================
    omp_twi_link u_link (
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .i_link_clear(r.link_clear),
        .i_deselect(i_deselect),
        .i_snap(r.snap),
        .o_start_tog(start_tog)
    );

    // ================================================================
    // Pin synchronisers and events
    // ================================================================
    // A falling power-down level triggers the link reset and clears flags and snapshot. [RQ7]
    assign pd_fall = r.pd_sy[2] && !r.pd_sy[1];
    // A toggle from the link marks a new transaction.
    assign start_ev = r.stt_sy[2] != r.stt_sy[1];
    // Not-ready joins signal loss and both lock losses. [RQ5]
    assign not_ready = r.los_sy[1] || r.tlol_sy[1] || r.rlol_sy[1];

    // ================================================================
    // Next-state logic
    // ================================================================
    always_comb begin
        next_r = r;
        // Every asynchronous pin passes two flip-flops.
        next_r.pd_sy = {r.pd_sy[1:0], i_power_down};
        next_r.off_sy = {r.off_sy[0], i_laser_off_req};
        next_r.los_sy = {r.los_sy[0], i_rx_signal_lost};
        next_r.tlol_sy = {r.tlol_sy[0], i_tx_lol};
        next_r.rlol_sy = {r.rlol_sy[0], i_rx_lol};
        next_r.stt_sy = {r.stt_sy[1:0], start_tog};

        // Reset stretch holding the link logic cleared. [RQ7]
        if (pd_fall) begin
            next_r.rst_cnt = `OMP_RST_CYC;
            next_r.flags = '0;
            next_r.snap = '0;
        end else if (r.rst_cnt != 5'h0) begin
            next_r.rst_cnt = r.rst_cnt - 5'h1;
        end
        next_r.link_clear = next_r.rst_cnt != 5'h0;

        // Stand-by while power-down is high; laser held off too. [RQ6] [RQ3]
        next_r.standby = r.pd_sy[1];
        next_r.laser_en = !r.off_sy[1] && !r.pd_sy[1];

        // Factory range checks, frozen during stand-by and skipped in the power-down fall cycle that clears them. [RQ16]
        if (!r.pd_sy[1] && !pd_fall) begin
            for (int p = 0; p < 5; p++) begin
                next_r.flags[p].hi_alarm = mon[p] > THR[p].hi_alarm;
                next_r.flags[p].lo_alarm = mon[p] < THR[p].lo_alarm;
                next_r.flags[p].hi_warn = mon[p] > THR[p].hi_warn;
                next_r.flags[p].lo_warn = mon[p] < THR[p].lo_warn;
            end
        end

        // Each transaction start, except in the power-down fall cycle, takes a fresh snapshot of live values. [RQ15]
        if (start_ev && !pd_fall) begin
            for (int p = 0; p < 5; p++) begin
                next_r.snap[`OMP_A_MON + 2 * p] = mon[p][15:8];
                next_r.snap[`OMP_A_MON + 2 * p + 1] = mon[p][7:0];
            end
            {next_r.snap[`OMP_A_FLAG + 2], next_r.snap[`OMP_A_FLAG + 1],
                next_r.snap[`OMP_A_FLAG]} = {4'h0, r.flags};
            // Status byte makes the interrupt cause readable. [RQ2]
            next_r.snap[`OMP_A_STAT] = {2'h0, r.standby, !r.laser_en, r.int_oe,
                r.los_sy[1], r.tlol_sy[1], r.rlol_sy[1]};
        end

        // Pins are open collector: enable low lets the pin float high.
        next_r.nr_oe = !not_ready; // [RQ5]
        next_r.los_oe = !r.los_sy[1]; // [RQ17]
        // Interrupt pulls low while any flag or not-ready stands. [RQ2]
        next_r.int_oe = (next_r.flags != '0) || not_ready;
        // The reference clock inputs feed no logic whatever. [RQ8]
    end

    // ================================================================
    // State register
    // ================================================================
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            r <= '0;
            r.rst_cnt <= `OMP_RST_CYC;
            r.link_clear <= 1'b1;
        end else if (i_clk_en) begin
            r <= next_r;
        end
    end

    // ================================================================
    // Outputs
    // ================================================================
    assign o_interrupt_oe = r.int_oe;
    // Presence pin is grounded inside the module at all times. [RQ4]
    assign o_absent_oe = 1'b1;
    assign o_not_ready_flag_oe = r.nr_oe;
    assign o_rx_signal_lost_oe = r.los_oe;
    assign o_laser_en = r.laser_en;
    assign o_standby = r.standby;

    // ================================================================
    // Checks
    // ================================================================
    sequence pd_fall_s;
        r.pd_sy[2] && !r.pd_sy[1];
    endsequence

    sequence start_s;
        r.stt_sy[2] != r.stt_sy[1];
    endsequence

    laser_off_a: assert property ( // [RQ3]
        r.off_sy[1] |=> !o_laser_en)
        else $error("Laser on while disable requested.");

    standby_hold_a: assert property ( // [RQ6]
        r.pd_sy[1] |=> (o_standby && !o_laser_en))
        else $error("Not in stand-by while power-down high.");

    reset_stretch_a: assert property ( // [RQ7]
        pd_fall_s |=> (r.link_clear && r.flags == '0) ##1 r.link_clear [*7])
        else $error("Power-down fall did not hold the link in reset.");

    not_ready_or_a: assert property ( // [RQ5]
        1'b1 |=> (o_not_ready_flag_oe == !($past(r.los_sy[1]) || $past(r.tlol_sy[1])
            || $past(r.rlol_sy[1]))))
        else $error("Not-ready pin is not the OR of the loss signals.");

    los_pin_a: assert property ( // [RQ17]
        r.los_sy[1] |=> !o_rx_signal_lost_oe)
        else $error("Signal-loss pin held low without signal.");

    absent_pin_a: assert property ( // [RQ4]
        o_absent_oe)
        else $error("Presence pin released.");

    temp_alarm_a: assert property ( // [RQ16] [RQ2]
        (!r.pd_sy[1] && !pd_fall && i_temp > THR[0].hi_alarm)
            |=> (r.flags[0].hi_alarm && o_interrupt_oe))
        else $error("High temperature alarm or interrupt missing.");

    snapshot_a: assert property ( // [RQ15]
        (start_s and !pd_fall) |=> (r.snap[`OMP_A_MON] == $past(i_temp[15:8])
            && r.snap[`OMP_A_MON + 1] == $past(i_temp[7:0])))
        else $error("Snapshot did not take the live temperature.");

endmodule

// file: sim/omp_host_model.sv
// ====================================================================
// Host controller on the two-wire link
// ====================================================================
module omp_host_model (
    // Resolved data line as seen on the wire.
    input wire logic i_sda,
    // Serial clock and data pull-down driven by the host.
    output logic o_scl,
    output logic o_sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // The clock idles high and stands still between frames.
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // One bit in a 32 ns period: drive while low, sample at the rise.
    task automatic bit_io(input logic b, output logic r);
        o_sda_oe = ~b;
        #8 o_scl = 1'b1;
        r = i_sda;
        #16 o_scl = 1'b0;
        #8;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        o_sda_oe = 1'b0;
        #8 o_scl = 1'b1;
        #8 o_sda_oe = 1'b1;
        #8 o_scl = 1'b0;
        #8;
    endtask

    // Stop: data rises while the clock is high, then the bus rests.
    task automatic stop();
        o_sda_oe = 1'b1;
        #8 o_scl = 1'b1;
        #8 o_sda_oe = 1'b0;
        #16;
    endtask

    // Byte MSB first, then the acknowledge bit in the other direction.
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ai, ak);
    endtask
endmodule

// file: sim/omp_mgmt_port_bench.sv
`include "omp_cfg.svh"
`define omp_chk(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end

// ====================================================================
// Self-checking bench of the management port
// ====================================================================
module omp_mgmt_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] thr = `OMP_THR_TEMP;
    logic clk = 0, rst = 1, desel = 0, off = 0, pd = 0, refp = 0, los = 0, tl = 0, rl = 0;
    logic [15:0] temp = 16'h4000;
    logic d_oe, h_oe, scl, int_oe, abs_oe, nr_oe, los_oe, las, sb, ak, oor, en = 1;
    logic [7:0] q, d0, d1, a;
    int fails = 0, checks_done = 0;
    // Open-drain data line with a pull-up.
    wire sda = ~(d_oe | h_oe);

    always #25 clk = ~clk;

    omp_host_model i_host (.i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
    omp_mgmt_port i_omp_mgmt_port (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(en),
        .i_deselect(desel), .i_laser_off_req(off), .i_power_down(pd),
        .i_ref_clock_in_p(refp), .i_ref_clock_in_n(~refp), .i_scl(scl), .i_sda(sda),
        .o_sda_oe(d_oe), .i_temp(temp), .i_bias(16'h4000), .i_tx_pwr(16'h4000),
        .i_rx_pwr(16'h4000), .i_vcc(16'h4000), .i_rx_signal_lost(los), .i_tx_lol(tl),
        .i_rx_lol(rl), .o_interrupt_oe(int_oe), .o_absent_oe(abs_oe),
        .o_not_ready_flag_oe(nr_oe), .o_rx_signal_lost_oe(los_oe), .o_laser_en(las),
        .o_standby(sb));

    // Waits for n edges and steps just past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // Writes two bytes from address ad on; k is the address acknowledge.
    task automatic wr(input logic [7:0] ad, b0, b1, output logic k);
        logic [7:0] x;
        logic y;
        i_host.start();
        i_host.xfer({`OMP_DEV_ADDR, 1'b0}, 1'b1, x, k);
        i_host.xfer(ad, 1'b1, x, y);
        i_host.xfer(b0, 1'b1, x, y);
        i_host.xfer(b1, 1'b1, x, y);
        i_host.stop();
    endtask

    // Random read of one byte, ended by a host no-acknowledge.
    task automatic rd(input logic [7:0] ad, output logic [7:0] r, output logic k);
        logic [7:0] x;
        logic y;
        i_host.start();
        i_host.xfer({`OMP_DEV_ADDR, 1'b0}, 1'b1, x, k);
        i_host.xfer(ad, 1'b1, x, y);
        i_host.start();
        i_host.xfer({`OMP_DEV_ADDR, 1'b1}, 1'b1, x, y);
        i_host.xfer(8'hff, 1'b1, r, y);
        i_host.stop();
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run time.
    initial begin
        #300000;
        fails++;
        stop_test();
    end

    // Main sequence of tests.
    initial begin
        void'($urandom(32'ha422));
        tick(8);
        rst = 0;
        tick(25);
        for (int n = 0; n < 12; n++) begin
            {los, tl, rl, off, refp} = 5'($urandom);
            temp = 16'($urandom);
            oor = (temp > thr[31:16]) | (temp < thr[15:0]);
            tick(5);
            `omp_chk("not_ready", ~(los | tl | rl), nr_oe)
            `omp_chk("sig_lost", ~los, los_oe)
            `omp_chk("laser", ~off, las)
            `omp_chk("absent", 1'b1, abs_oe)
            `omp_chk("intr", los | tl | rl | oor, int_oe)
        end
        // Clock enable low freezes the laser output at its old level.
        en = 0;
        off = ~off;
        tick(5);
        `omp_chk("freeze", off, las)
        en = 1;
        tick(5);
        `omp_chk("unfreeze", ~off, las)
        $display("test pins done");
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        a = 8'h80 | 8'($urandom % 127);
        wr(a, d0, d1, ak);
        `omp_chk("wr_ack", 1'b0, ak)
        rd(8'(a + 1), q, ak);
        `omp_chk("seq", d1, q)
        rd(a, q, ak);
        `omp_chk("ram", d0, q)
        wr(8'h0e, d0, d1, ak);
        rd(8'h0e, q, ak);
        `omp_chk("prot", 8'h00, q)
        rd(8'h00, q, ak);
        `omp_chk("temp_hi", temp[15:8], q)
        rd(8'h01, q, ak);
        `omp_chk("temp_lo", temp[7:0], q)
        rd(8'h0a, q, ak);
        `omp_chk("flag_hi", {4'h0, temp > thr[63:48], temp < thr[47:32]}, q[7:2])
        `omp_chk("flag_lo", {temp > thr[31:16], temp < thr[15:0]}, q[1:0])
        rd(8'h0d, q, ak);
        `omp_chk("status", {3'h0, off, los | tl | rl | oor, los, tl, rl}, q)
        $display("test memory done");
        desel = 1;
        tick(3);
        rd(a, q, ak);
        `omp_chk("desel", 1'b1, ak)
        desel = 0;
        tick(3);
        // The select synchroniser runs on the serial clock, so one frame flushes it.
        rd(a, q, ak);
        rd(a, q, ak);
        `omp_chk("sel", 1'b0, ak)
        $display("test deselect done");
        pd = 1;
        tick(5);
        `omp_chk("standby", 1'b1, sb)
        pd = 0;
        tick(4);
        `omp_chk("wake", 1'b0, sb)
        rd(a, q, ak);
        `omp_chk("link_rst", 1'b1, ak)
        tick(25);
        rd(a, q, ak);
        `omp_chk("link_back", 1'b0, ak)
        $display("test power down done");
        stop_test();
    end
endmodule
